// [bench/mms_ep_model.sv]
`timescale 1ns/100ps
module mms_ep_model (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Issue from the router
    input wire ep_valid,
    input wire ep_write,
    input wire ep_posted,
    input wire [31:0] ep_mask,
    // Completions back
    output reg [31:0] ep_rsp_valid = 32'h0,
    output wire [1023:0] ep_rsp_data
);
    // Instances still owing an answer
    reg [31:0] pend_q;
    reg [1:0] wait_q;
    // Alternate prompt and slow answers
    reg slow_q;

    // Posted writes are sunk silently, everything else answered
    always @(posedge clk) begin
        ep_rsp_valid <= 32'h0;
        if (!rstn) begin
            pend_q <= 32'h0;
            wait_q <= 2'h0;
            slow_q <= 1'b0;
        end else if (ep_valid && !(ep_write && ep_posted)) begin
            slow_q <= !slow_q;
            if (slow_q) begin
                pend_q <= ep_mask;
                wait_q <= 2'h3;
            end else begin
                ep_rsp_valid <= ep_mask;
            end
        end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end else if (pend_q != 32'h0) begin
            ep_rsp_valid <= pend_q;
            pend_q <= 32'h0;
        end
    end

    // Each instance answers with its own index; inverted when idle
    genvar g;
    for (g = 0; g < 32; g = g + 1) begin : g_data
        assign ep_rsp_data[32*g +: 32] = ep_rsp_valid[g] ? (32'hd0000000 | g) :
            ~(32'hd0000000 | g);
    end
endmodule

// [bench/mms_router_assertions.sv]
`timescale 1ns/100ps
`include "mms_defs.vh"
module mms_router_assertions (
    // Clock and control
    input wire clk,
    input wire rstn,
    input wire ce,
    // Initiator side
    input wire req_valid,
    input wire req_ready,
    input wire req_write,
    input wire req_posted,
    input wire [23:0] req_addr,
    input wire rsp_valid,
    input wire [31:0] rsp_data,
    input wire rsp_dummy,
    // Endpoint side
    input wire ep_valid,
    input wire ep_write,
    input wire [2:0] ep_group,
    input wire [23:0] ep_addr,
    input wire [31:0] ep_mask
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Request accepted this cycle
    wire take = req_valid && req_ready && ce;
    wire np = !(req_write && req_posted);

    a_reset_idle: assert property ($rose(rstn) |-> req_ready && !rsp_valid && !ep_valid)
        else $error("outputs not idle after reset");
    a_steer_local: assert property (take && np && req_addr == `MMS_OFF_STEER
        |=> rsp_valid && !rsp_dummy && !ep_valid) else $error("steering access left the block");
    a_steer_layout: assert property (take && !req_write && req_addr == `MMS_OFF_STEER
        |=> rsp_data[31:17] == 0 && rsp_data[15:12] == 0 && rsp_data[7:3] == 0)
        else $error("steering read has stray bits");
    a_posted_quiet: assert property (take && !np |=> !rsp_valid)
        else $error("posted write got a completion");
    a_dummy_zero: assert property (rsp_valid && rsp_dummy |-> rsp_data == 32'h0)
        else $error("dummy completion carries data");
    a_single_inst: assert property (ep_valid && ep_group == `MMS_GRP_NONE |-> ep_mask == 32'h1)
        else $error("plain target sent to several instances");
    a_fields_hold: assert property (!ep_valid && $past(rstn) |-> $stable(ep_addr) && $stable(ep_mask))
        else $error("endpoint fields moved without an issue");
    a_issue_once: assert property (ep_valid |=> !ep_valid)
        else $error("endpoint issue longer than one cycle");
    a_read_busy: assert property (ep_valid && !ep_write |-> !req_ready)
        else $error("ready while a read is out");
    a_read_returns: assert property (ep_valid && !ep_write |-> ##[2:12] rsp_valid)
        else $error("read completion missing");
endmodule

// [bench/mms_router_bench.sv]
`timescale 1ns/100ps
`include "mms_defs.vh"
module mms_router_bench;
    // Stimulus
    reg clk, rstn, ce, req_valid, req_write, req_posted, top_domain_up, render_domain_up;
    reg [23:0] req_addr;
    reg [31:0] req_wdata, fuse_compute, fuse_geometry;
    reg [3:0] fuse_memory_cache;
    reg [1:0] config_size;
    // Design outputs
    wire req_ready, rsp_valid, rsp_dummy, ep_valid, ep_write, ep_posted;
    wire top_wake_req, render_wake_req;
    wire [31:0] rsp_data, ep_wdata, ep_mask, ep_rsp_valid;
    wire [23:0] ep_addr;
    wire [2:0] ep_group;
    wire [1023:0] ep_rsp_data;
    // Bookkeeping
    integer miscompares, checks_done, ep_cnt, i;
    reg [31:0] last_mask, rd;
    reg dum;

    mms_router uut (.clk, .rstn, .ce, .req_valid, .req_ready, .req_write, .req_posted,
        .req_addr, .req_wdata, .rsp_valid, .rsp_data, .rsp_dummy, .ep_valid, .ep_write,
        .ep_posted, .ep_group, .ep_addr, .ep_wdata, .ep_mask, .ep_rsp_valid, .ep_rsp_data,
        .fuse_compute, .fuse_geometry, .fuse_memory_cache, .config_size, .top_domain_up,
        .render_domain_up, .top_wake_req, .render_wake_req);
    mms_ep_model ep (.clk, .rstn, .ep_valid, .ep_write, .ep_posted, .ep_mask,
        .ep_rsp_valid, .ep_rsp_data);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Record every issue toward the endpoints
    always @(posedge clk) begin
        if (ep_valid === 1'b1) begin
            ep_cnt <= ep_cnt + 1;
            last_mask <= ep_mask;
        end
    end

    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // One transfer; held until taken, then wait for the completion, or four cycles for a posted write
    task acc(input w, input p, input [23:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            req_valid <= 1'b1;
            req_write <= w;
            req_posted <= p;
            req_addr <= a;
            req_wdata <= d;
            n = 0;
            @(negedge clk);
            while (req_ready !== 1'b1 && n < 50) begin
                @(negedge clk);
                n = n + 1;
            end
            @(posedge clk);
            req_valid <= 1'b0;
            if (w && p) begin
                repeat (4) @(posedge clk);
            end else begin
                @(negedge clk);
                while (rsp_valid !== 1'b1 && n < 100) begin
                    @(negedge clk);
                    n = n + 1;
                end
                rd = rsp_data;
                dum = rsp_dummy;
                if (n >= 50) chk(32'h0, 32'h1);
            end
        end
    endtask

    task rdchk(input [23:0] a, input [31:0] ed, input ex_dum);
        begin
            acc(1'b0, 1'b0, a, 32'h0);
            chk(rd, ed);
            chk({31'h0, dum}, {31'h0, ex_dum});
        end
    endtask

    task steer(input mc, input [3:0] sl, input [2:0] ss);
        acc(1'b1, 1'b0, `MMS_OFF_STEER, {15'h0, mc, 4'h0, sl, 5'h0, ss});
    endtask

    // Pins are synchronised, so let them settle before use
    task setup(input [31:0] f, input [3:0] l3, input [1:0] cs, input up);
        begin
            @(posedge clk);
            fuse_compute <= f;
            fuse_geometry <= f;
            fuse_memory_cache <= l3;
            config_size <= cs;
            render_domain_up <= up;
            top_domain_up <= up;
            repeat (6) @(posedge clk);
        end
    endtask

    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask

    initial begin
        #100000;
        miscompares = miscompares + 1;
        final_report;
    end

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_posted = 1'b0;
        req_addr = 24'h0;
        req_wdata = 32'h0;
        fuse_compute = 32'hffffffff;
        fuse_geometry = 32'hffffffff;
        fuse_memory_cache = 4'hf;
        config_size = 2'h0;
        top_domain_up = 1'b1;
        render_domain_up = 1'b1;
        miscompares = 0;
        checks_done = 0;
        ep_cnt = 0;
        last_mask = 32'h0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        rdchk(`MMS_OFF_STEER, 32'h00010000, 1'b0);
        rdchk(`MMS_OFF_C_FUSE, 32'hffffffff, 1'b0);
        acc(1'b1, 1'b0, `MMS_OFF_C_FUSE, 32'h0);
        rdchk(`MMS_OFF_C_FUSE, 32'hffffffff, 1'b0);
        rdchk(`MMS_OFF_G_FUSE, 32'hffffffff, 1'b0);
        rdchk(`MMS_OFF_L3_FUSE, 32'h0000000f, 1'b0);
        // Multicast ignores selectors on writes, picks one reply on reads
        steer(1'b1, 4'h3, 3'h2);
        acc(1'b1, 1'b0, `MMS_DSS_LO, 32'h5a5a5a5a);
        chk(last_mask, 32'hffffffff);
        steer(1'b1, 4'h1, 3'h2);
        rdchk(`MMS_DSS_LO, 32'hd0000006, 1'b0);
        chk(last_mask, 32'hffffffff);
        steer(1'b0, 4'h2, 3'h1);
        rdchk(`MMS_DSS_LO, 32'hd0000009, 1'b0);
        chk(last_mask, 32'h00000200);
        steer(1'b0, 4'hd, 3'h7);
        rdchk(`MMS_L3_LO, 32'hd0000017, 1'b0);
        rdchk(24'h00a000, 32'hd0000000, 1'b0);
        chk(last_mask, 32'h00000001);
        // Fused-off subslice 9 and geometry slice 6
        setup(32'hf0fffdff, 4'hf, 2'h0, 1'b1);
        steer(1'b0, 4'h2, 3'h1);
        rdchk(`MMS_DSS_LO, 32'h0, 1'b1);
        i = ep_cnt;
        acc(1'b1, 1'b1, `MMS_DSS_LO, 32'h1);
        chk(ep_cnt, i);
        steer(1'b0, 4'h6, 3'h0);
        rdchk(`MMS_GSLICE_LO, 32'h0, 1'b1);
        steer(1'b0, 4'h7, 3'h0);
        rdchk(`MMS_GSLICE_LO, 32'hd0000007, 1'b0);
        steer(1'b0, 4'h9, 3'h0);
        rdchk(`MMS_GSLICE_LO, 32'h0, 1'b1);
        // Quadrant 3 dead only when its cache fuse is off too
        for (i = 0; i < 2; i = i + 1) begin
            setup(32'h00ffffff, i ? 4'hf : 4'h7, 2'h0, 1'b1);
            steer(1'b0, 4'h3, 3'h0);
            rdchk(`MMS_MSLICE_LO, i ? 32'hd0000003 : 32'h0, !i);
            steer(1'b0, 4'h7, 3'h0);
            rdchk(`MMS_FAB_LO, i ? 32'hd0000007 : 32'h0, !i);
            steer(1'b0, 4'h6, 3'h0);
            rdchk(`MMS_L3_LO, i ? 32'hd0000018 : 32'h0, !i);
        end
        // Reduced sizes: sub 1 and 5 on mid, sub 5 and 3 on small
        for (i = 0; i < 4; i = i + 1) begin
            setup(32'hffffffff, 4'hf, i < 2 ? 2'h1 : 2'h2, 1'b1);
            steer(1'b0, 4'h0, 12'b011_101_101_001 >> (3 * i));
            rdchk(`MMS_MSIDE_LO, 4'b0101 >> i & 1 ? 32'h0 :
                (32'hd0000000 | (12'b011_101_101_001 >> (3 * i) & 7)), 4'b0101 >> i & 1);
        end
        // Both domains asleep, then woken
        setup(32'hffffffff, 4'hf, 2'h0, 1'b0);
        steer(1'b0, 4'h0, 3'h0);
        rdchk(`MMS_DSS_LO, 32'h0, 1'b1);
        rdchk(`MMS_MSLICE_LO, 32'h0, 1'b1);
        rdchk(`MMS_AO_LO, 32'hd0000000, 1'b0);
        acc(1'b1, 1'b0, `MMS_OFF_RENDER_REQ, 32'h1);
        repeat (2) @(posedge clk);
        chk(render_wake_req, 32'h1);
        rdchk(`MMS_OFF_RENDER_ACK, 32'h0, 1'b0);
        setup(32'hffffffff, 4'hf, 2'h0, 1'b1);
        rdchk(`MMS_MSLICE_LO, 32'hd0000000, 1'b0);
        rdchk(`MMS_OFF_RENDER_ACK, 32'h1, 1'b0);
        acc(1'b1, 1'b0, `MMS_OFF_TOP_REQ, 32'h1);
        repeat (2) @(posedge clk);
        chk(top_wake_req, 32'h1);
        rdchk(`MMS_OFF_TOP_ACK, 32'h1, 1'b0);
        final_report;
    end
endmodule

bind mms_router mms_router_assertions u_chk (.clk, .rstn, .ce, .req_valid, .req_ready,
    .req_write, .req_posted, .req_addr, .rsp_valid, .rsp_data, .rsp_dummy, .ep_valid,
    .ep_write, .ep_group, .ep_addr, .ep_mask);

// [verilog/mms_defs.vh]
`ifndef MMS_DEFS_VH
`define MMS_DEFS_VH
// Local register offsets
`define MMS_OFF_RENDER_ACK 24'h000d84
`define MMS_OFF_STEER 24'h0020cc
`define MMS_OFF_L3_FUSE 24'h009118
`define MMS_OFF_G_FUSE 24'h00913c
`define MMS_OFF_C_FUSE 24'h009144
`define MMS_OFF_TOP_REQ 24'h00a188
`define MMS_OFF_RENDER_REQ 24'h00a278
`define MMS_OFF_TOP_ACK 24'h130044
// Steering register field positions
`define MMS_STEER_MC_BIT 16
`define MMS_STEER_SL_LSB 8
`define MMS_STEER_SS_LSB 0
// Steering reset values
`define MMS_STEER_MC_RST 1'h1
`define MMS_STEER_SL_RST 4'h0
`define MMS_STEER_SS_RST 3'h0
// Wake request reset value
`define MMS_WAKE_RST 32'h0
// Replication group codes
`define MMS_GRP_NONE 3'h0
`define MMS_GRP_DSS 3'h1
`define MMS_GRP_GSLICE 3'h2
`define MMS_GRP_L3 3'h3
`define MMS_GRP_MSLICE 3'h4
`define MMS_GRP_FAB 3'h5
`define MMS_GRP_MSIDE 3'h6
// Replicated address ranges, inclusive
`define MMS_DSS_LO 24'h009520
`define MMS_DSS_HI 24'h00955f
`define MMS_GSLICE_LO 24'h00d800
`define MMS_GSLICE_HI 24'h00d87f
`define MMS_L3_LO 24'h00b100
`define MMS_L3_HI 24'h00b3ff
`define MMS_MSLICE_LO 24'h00c800
`define MMS_MSLICE_HI 24'h00cfff
`define MMS_FAB_LO 24'h00b000
`define MMS_FAB_HI 24'h00b0ff
`define MMS_MSIDE_LO 24'h00ee00
`define MMS_MSIDE_HI 24'h00eeff
// Always-on range
`define MMS_AO_LO 24'h00d000
`define MMS_AO_HI 24'h00d7ff
// Configuration size codes
`define MMS_SKU_FULL 2'h0
`define MMS_SKU_MID 2'h1
`define MMS_SKU_SMALL 2'h2
// Dummy completion data
`define MMS_DUMMY_DATA 32'h0
`endif

// [verilog/mms_group_map.v]
`timescale 1ns/100ps
`include "mms_defs.vh"
module mms_group_map (
    // Target group and selectors
    input wire [2:0] grp,
    input wire [3:0] slice,
    input wire [2:0] sub,
    // Fuse state and configuration size
    input wire [31:0] fuse_c,
    input wire [31:0] fuse_g,
    input wire [3:0] fuse_l3,
    input wire [1:0] sku,
    // Enabled instances and selected instance
    output wire [31:0] en_mask,
    output reg [4:0] sel_idx,
    output wire sel_ok
);
    wire [31:0] comb = fuse_g | fuse_c;
    wire [127:0] comb_pad = {96'h0, comb}; // Padded for group slices
    wire [3:0] quad_dss; // Any subslice alive per quadrant
    wire [31:0] live_pad; // Quadrant memory side kept alive
    reg sel_rng; // Selector inside the group

    assign quad_dss[0] = |(comb[7:0] & 8'hff);
    assign quad_dss[1] = |(comb[15:8] & 8'hff);
    assign quad_dss[2] = |(comb[23:16] & 8'hff);
    assign quad_dss[3] = |(comb[31:24] & 8'hff);
    assign live_pad = {28'h0, fuse_l3 | quad_dss};

    // One enable per instance slot
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_inst
            wire gs_en = |comb_pad[4*i +: 4];
            wire ms_en = (i < 8) && ((sku == `MMS_SKU_FULL) ||
                ((sku == `MMS_SKU_MID) && (i >= 2) && (i <= 5)) ||
                (i == 2) || (i == 3));
            assign en_mask[i] =
                (grp == `MMS_GRP_DSS) ? comb[i] :
                (grp == `MMS_GRP_GSLICE) ? ((i < 8) && gs_en) :
                (grp == `MMS_GRP_L3) ? live_pad[i/8] :
                (grp == `MMS_GRP_MSLICE) ? live_pad[i] :
                (grp == `MMS_GRP_FAB) ? ((i < 8) && live_pad[i/2]) :
                (grp == `MMS_GRP_MSIDE) ? ms_en :
                (i == 0);
        end
    endgenerate

    // Selector fields to flat instance index
    always @* begin
        sel_idx = 5'h0;
        sel_rng = 1'b1;
        case (grp)
            `MMS_GRP_DSS: begin
                sel_idx = {slice[2:0], sub[1:0]};
                sel_rng = ~slice[3] & ~sub[2];
            end
            `MMS_GRP_GSLICE, `MMS_GRP_FAB: begin
                sel_idx = {2'h0, slice[2:0]};
                sel_rng = ~slice[3];
            end
            `MMS_GRP_L3: begin
                sel_idx = {slice[2:0], sub[1:0]};
            end
            `MMS_GRP_MSLICE: begin
                sel_idx = {3'h0, slice[1:0]};
                sel_rng = (slice[3:2] == 2'h0);
            end
            `MMS_GRP_MSIDE: begin
                sel_idx = {2'h0, sub};
            end
            default: begin
                sel_idx = 5'h0;
            end
        endcase
    end

    assign sel_ok = sel_rng & en_mask[sel_idx];
endmodule

// [verilog/mms_router.v]
`timescale 1ns/100ps
`include "mms_defs.vh"
// How it works
// - Multicast write reaches all instances, selectors ignored.
// - Multicast read: all answer, selected one returned.
// - Unicast sends reads and writes to one instance.
// - Reset gives multicast, slice zero, subslice zero.
// - Non-replicated targets ignore multicast, route normally.
// - Command streamer steering register sits at 0x20cc.
// - Memory-side group: eight, reduced sizes terminate some.
// - Geometry slice terminated when its subslices off.
// - Subslice: four per slice, terminated when fused.
// - Bank index from slice and subslice bits.
// - Quadrant banks terminated only if fully dead.
// - Memory slice per quadrant, same termination.
// - Slice pairs select cache fabric of slice.
// - Subslice enabled if geometry or compute fuse.
// - Fuse states mirrored read-only at fixed offsets.
// - Powered-down domains terminated; initiators wake first.
// - Terminator absorbs posted, completes non-posted.
// - Terminated writes dropped, reads return zero.
// - Always-on registers need no wake.
module mms_router #(
    parameter AW = 24,
    parameter DW = 32
) (
    // Clock, reset and enable
    input wire clk,
    input wire rstn,
    input wire ce,
    // Initiator request
    input wire req_valid,
    output wire req_ready,
    input wire req_write,
    input wire req_posted,
    input wire [AW-1:0] req_addr,
    input wire [DW-1:0] req_wdata,
    // Initiator completion
    output wire rsp_valid,
    output wire [DW-1:0] rsp_data,
    output wire rsp_dummy,
    // Endpoint request, one enable per instance
    output wire ep_valid,
    output wire ep_write,
    output wire ep_posted,
    output wire [2:0] ep_group,
    output wire [AW-1:0] ep_addr,
    output wire [DW-1:0] ep_wdata,
    output wire [31:0] ep_mask,
    // Endpoint completions
    input wire [31:0] ep_rsp_valid,
    input wire [32*DW-1:0] ep_rsp_data,
    // Fuse and configuration pins
    input wire [31:0] fuse_compute,
    input wire [31:0] fuse_geometry,
    input wire [3:0] fuse_memory_cache,
    input wire [1:0] config_size,
    // Power domain state pins
    input wire top_domain_up,
    input wire render_domain_up,
    // Wake requests toward power control
    output wire top_wake_req,
    output wire render_wake_req
);
    // One-hot states
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_SEND = 3'h2;
    localparam [2:0] ST_WAIT = 3'h4;

    reg [2:0] st_q; // Cycle state
    reg mc_q; // Steering multicast
    reg [3:0] sl_q; // Steering slice selector
    reg [2:0] ss_q; // Steering subslice selector
    reg [DW-1:0] top_req_q; // Top domain wake request word
    reg [DW-1:0] ren_req_q; // Render wake request word
    reg rsp_valid_q; // Completion pulse
    reg [DW-1:0] rsp_data_q; // Completion data
    reg rsp_dummy_q; // Completion made on behalf of endpoint
    reg ep_valid_q; // Endpoint issue pulse
    reg ep_write_q;
    reg ep_posted_q;
    reg [2:0] ep_group_q;
    reg [AW-1:0] ep_addr_q;
    reg [DW-1:0] ep_wdata_q;
    reg [31:0] ep_mask_q;
    reg [31:0] pend_q; // Instances still owing a completion
    reg [4:0] sel_q; // Instance whose data is returned
    reg rd_ok_q; // Selected instance is live

    // Synchronised pins
    wire [31:0] f_c;
    wire [31:0] f_g;
    wire [3:0] f_l3;
    wire [1:0] sku;
    wire top_up;
    wire ren_up;

    // Decode results
    reg [2:0] grp; // Replication group of the address
    reg ao; // Address in always-on range
    reg loc_hit; // Address is a local register
    reg [DW-1:0] loc_rd; // Local read data
    wire [31:0] en_mask;
    wire [4:0] sel_idx;
    wire sel_ok;
    wire dom_up;
    reg [31:0] tgt_mask; // Instances this cycle goes to
    wire take;
    wire [31:0] pend_left;
    wire [DW-1:0] sel_data;

    // Fuses, size strap and power state come from other domains
    mms_sync #(
        .W(72)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .din({fuse_compute, fuse_geometry, fuse_memory_cache, config_size,
            top_domain_up, render_domain_up}),
        .dout({f_c, f_g, f_l3, sku, top_up, ren_up})
    );

    // Per-instance enables from fuses
    mms_group_map u_map (
        .grp(grp),
        .slice(sl_q),
        .sub(ss_q),
        .fuse_c(f_c),
        .fuse_g(f_g),
        .fuse_l3(f_l3),
        .sku(sku),
        .en_mask(en_mask),
        .sel_idx(sel_idx),
        .sel_ok(sel_ok)
    );

    // Address to replication group
    always @* begin
        grp = `MMS_GRP_NONE;
        ao = 1'b0;
        if ((req_addr >= `MMS_DSS_LO) && (req_addr <= `MMS_DSS_HI)) begin
            grp = `MMS_GRP_DSS;
        end else if ((req_addr >= `MMS_GSLICE_LO) && (req_addr <= `MMS_GSLICE_HI)) begin
            grp = `MMS_GRP_GSLICE;
        end else if ((req_addr >= `MMS_L3_LO) && (req_addr <= `MMS_L3_HI)) begin
            grp = `MMS_GRP_L3;
        end else if ((req_addr >= `MMS_MSLICE_LO) && (req_addr <= `MMS_MSLICE_HI)) begin
            grp = `MMS_GRP_MSLICE;
        end else if ((req_addr >= `MMS_FAB_LO) && (req_addr <= `MMS_FAB_HI)) begin
            grp = `MMS_GRP_FAB;
        end else if ((req_addr >= `MMS_MSIDE_LO) && (req_addr <= `MMS_MSIDE_HI)) begin
            grp = `MMS_GRP_MSIDE;
        end else if ((req_addr >= `MMS_AO_LO) && (req_addr <= `MMS_AO_HI)) begin
            ao = 1'b1;
        end
    end

    // Local register decode and read data
    always @* begin
        loc_hit = 1'b1;
        loc_rd = `MMS_DUMMY_DATA;
        if (req_addr == `MMS_OFF_STEER) begin
            loc_rd = {15'h0, mc_q, 4'h0, sl_q, 5'h0, ss_q};
        end else if (req_addr == `MMS_OFF_C_FUSE) begin
            loc_rd = f_c;
        end else if (req_addr == `MMS_OFF_G_FUSE) begin
            loc_rd = f_g;
        end else if (req_addr == `MMS_OFF_L3_FUSE) begin
            loc_rd = {28'h0, f_l3};
        end else if (req_addr == `MMS_OFF_TOP_REQ) begin
            loc_rd = top_req_q;
        end else if (req_addr == `MMS_OFF_RENDER_REQ) begin
            loc_rd = ren_req_q;
        end else if (req_addr == `MMS_OFF_TOP_ACK) begin
            loc_rd = {31'h0, top_req_q[0] & top_up}; // Ack needs power up
        end else if (req_addr == `MMS_OFF_RENDER_ACK) begin
            loc_rd = {31'h0, ren_req_q[0] & ren_up};
        end else begin
            loc_hit = 1'b0;
        end
    end

    // Power state of the domain behind the address
    assign dom_up = ao ? 1'b1 :
        ((grp == `MMS_GRP_DSS) || (grp == `MMS_GRP_GSLICE)) ? ren_up : top_up;

    // Instance set for this cycle, empty means terminate
    always @* begin
        tgt_mask = 32'h0;
        if (!dom_up) begin
            tgt_mask = 32'h0;
        end else if (grp == `MMS_GRP_NONE) begin
            tgt_mask = en_mask;
        end else if (mc_q) begin
            tgt_mask = en_mask;
        end else if (sel_ok) begin
            tgt_mask = 32'h1 << sel_idx;
        end
    end

    assign req_ready = (st_q == ST_IDLE);
    assign take = req_valid & req_ready & ce;
    assign pend_left = pend_q & ~ep_rsp_valid;
    assign sel_data = ep_rsp_data[sel_q*DW +: DW];

    // Main sequencer; all state frozen while ce is low
    always @(posedge clk) begin
        if (!rstn) begin
            st_q <= ST_IDLE;
            mc_q <= `MMS_STEER_MC_RST;
            sl_q <= `MMS_STEER_SL_RST;
            ss_q <= `MMS_STEER_SS_RST;
            top_req_q <= `MMS_WAKE_RST;
            ren_req_q <= `MMS_WAKE_RST;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= `MMS_DUMMY_DATA;
            rsp_dummy_q <= 1'b0;
            ep_valid_q <= 1'b0;
            ep_write_q <= 1'b0;
            ep_posted_q <= 1'b0;
            ep_group_q <= `MMS_GRP_NONE;
            ep_addr_q <= {AW{1'b0}};
            ep_wdata_q <= {DW{1'b0}};
            ep_mask_q <= 32'h0;
            pend_q <= 32'h0;
            sel_q <= 5'h0;
            rd_ok_q <= 1'b0;
        end else if (ce) begin
            // Pulses last one cycle
            rsp_valid_q <= 1'b0;
            ep_valid_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (take && loc_hit) begin
                        // Local registers answer at once
                        if (req_write && (req_addr == `MMS_OFF_STEER)) begin
                            mc_q <= req_wdata[`MMS_STEER_MC_BIT];
                            sl_q <= req_wdata[`MMS_STEER_SL_LSB +: 4];
                            ss_q <= req_wdata[`MMS_STEER_SS_LSB +: 3];
                        end
                        if (req_write && (req_addr == `MMS_OFF_TOP_REQ)) begin
                            top_req_q <= req_wdata;
                        end
                        if (req_write && (req_addr == `MMS_OFF_RENDER_REQ)) begin
                            ren_req_q <= req_wdata;
                        end
                        if (!(req_write && req_posted)) begin
                            rsp_valid_q <= 1'b1;
                            rsp_data_q <= req_write ? `MMS_DUMMY_DATA : loc_rd;
                            rsp_dummy_q <= 1'b0;
                        end
                    end else if (take && (tgt_mask == 32'h0)) begin
                        // Terminated: posted absorbed, others get dummy
                        if (!(req_write && req_posted)) begin
                            rsp_valid_q <= 1'b1;
                            rsp_data_q <= `MMS_DUMMY_DATA;
                            rsp_dummy_q <= 1'b1;
                        end
                    end else if (take) begin
                        // Issue with the steering seen now
                        ep_valid_q <= 1'b1;
                        ep_write_q <= req_write;
                        ep_posted_q <= req_write & req_posted;
                        ep_group_q <= grp;
                        ep_addr_q <= req_addr;
                        ep_wdata_q <= req_wdata;
                        ep_mask_q <= tgt_mask;
                        pend_q <= (req_write && req_posted) ? 32'h0 : tgt_mask;
                        sel_q <= sel_idx;
                        rd_ok_q <= (grp == `MMS_GRP_NONE) | sel_ok;
                        rsp_data_q <= `MMS_DUMMY_DATA;
                        st_q <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    // Posted writes need no completion
                    st_q <= ep_posted_q ? ST_IDLE : ST_WAIT;
                end
                ST_WAIT: begin
                    // Collect all; keep only the selected data
                    pend_q <= pend_left;
                    if (!ep_write_q && rd_ok_q && ep_rsp_valid[sel_q] && pend_q[sel_q]) begin
                        rsp_data_q <= sel_data;
                    end
                    if (pend_left == 32'h0) begin
                        rsp_valid_q <= 1'b1;
                        rsp_dummy_q <= ~ep_write_q & ~rd_ok_q;
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Output drives
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign rsp_dummy = rsp_dummy_q;
    assign ep_valid = ep_valid_q;
    assign ep_write = ep_write_q;
    assign ep_posted = ep_posted_q;
    assign ep_group = ep_group_q;
    assign ep_addr = ep_addr_q;
    assign ep_wdata = ep_wdata_q;
    assign ep_mask = ep_mask_q;
    assign top_wake_req = top_req_q[0];
    assign render_wake_req = ren_req_q[0];
endmodule

// [verilog/mms_sync.v]
`timescale 1ns/100ps
module mms_sync #(
    parameter W = 8
) (
    // Clock and control
    input wire clk,
    input wire rstn,
    input wire ce,
    // Asynchronous levels in, filtered levels out
    input wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] s1_q; // First stage, read only by s2_q
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    reg [W-1:0] out_q; // Accepted value

    // Three stages; a bit moves only once stages two and three agree
    always @(posedge clk) begin
        if (!rstn) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
            out_q <= {W{1'b0}};
        end else if (ce) begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= (s2_q & s3_q) | (out_q & (s2_q ^ s3_q));
        end
    end

    assign dout = out_q;
endmodule
